// ### rtl/stt_fifo.sv
// byte fifo with a registered output stage
`timescale 1ns/1ns
module stt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic clk,
  input  wire logic clr,   // synchronous clear
  stt_stream_if.snk in_s,  // fill side
  stt_stream_if.src out_s, // drain side
  output logic      empty  // nothing stored, nothing offered
);
  import stt_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;  // storage
    logic [AW-1:0]           wp;   // write pointer
    logic [AW-1:0]           rp;   // read pointer
    logic [AW:0]             cnt;  // words in storage
    logic                    ov;   // output stage valid
    logic [W-1:0]            od;   // output stage data
  } stt_fifo_s;
  stt_fifo_s f_r, f_nxt;
  logic push, pop;
  // honest full: refuse once storage is full
  assign in_s.ready = (f_r.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = f_r.ov;
  assign out_s.data  = f_r.od;
  assign empty = (f_r.cnt == '0) && !f_r.ov;
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    f_nxt = f_r;
    push = in_s.valid && in_s.ready;
    pop  = 1'b0;
    // refill output stage when it is free or being taken
    if (!f_r.ov || out_s.ready) begin
      if (f_r.cnt != '0) begin
        pop = 1'b1;
        f_nxt.od = f_r.mem[f_r.rp];
        f_nxt.ov = 1'b1;
        f_nxt.rp = f_r.rp + 1'b1;
      end else begin
        f_nxt.ov = 1'b0;
      end
    end
    if (push) begin
      f_nxt.mem[f_r.wp] = in_s.data;
      f_nxt.wp = f_r.wp + 1'b1;
    end
    f_nxt.cnt = f_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  // register the state; memory contents need no reset
  always_ff @(posedge clk) begin
    f_r <= f_nxt;
    if (clr) begin
      f_r.wp  <= '0;
      f_r.rp  <= '0;
      f_r.cnt <= '0;
      f_r.ov  <= 1'b0;
      f_r.od  <= '0;
    end
  end
endmodule

// ### rtl/stt_params.svh
// constants of the serial test transmitter: map, fields, keys, sizes
// Functional notes
// - control write needs key 0x0007, write, 0x00b9
// - missing or wrong key discards the control write
// - control register sixteen bits, resets to zero
// - bits 8..5 nonzero while sending, else zero
// - bits 4..2 give byte count minus one
// - bytes low then high, register one first
// - bit one resets whole transmitter, reads zero
// - bit zero enables, software clears to disable
// - wait until needed data registers are written
// - bit timing from baud timer overflow pulse
// - readback differs while busy, then matches written
`ifndef STT_PARAMS_SVH
`define STT_PARAMS_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define STT_ADDR_KEY_FIRST  32'hffff0880
`define STT_ADDR_CTRL       32'hffff0884
`define STT_ADDR_KEY_SECOND 32'hffff0888
`define STT_ADDR_DAT0       32'hffff088c
`define STT_ADDR_DAT1       32'hffff0890
`define STT_ADDR_DAT2       32'hffff0894
// ---------------------------------------------------------------
// key values, reset values and control fields
// ---------------------------------------------------------------
`define STT_KEY_FIRST_VAL   16'h0007
`define STT_KEY_SECOND_VAL  16'h00b9
`define STT_CTRL_RESET      5'h00
`define STT_DAT_RESET       16'h0000
`define STT_CTRL_EN         0
`define STT_CTRL_SRST       1
`define STT_CTRL_CNT_LO     2
`define STT_CTRL_CNT_HI     4
`define STT_CTRL_STATE_LO   5
`define STT_CTRL_STATE_HI   8
`define STT_CNT_MAX         3'h5
`define STT_STATE_LOAD      4'h1
`define STT_STATE_SEND      4'h2
// ---------------------------------------------------------------
// data path sizes
// ---------------------------------------------------------------
`define STT_FIFO_DEPTH      16
`define STT_BYTE_W          8
`define STT_FRAME_BITS      4'hc
`endif

// ### rtl/stt_pkg.sv
// types shared by the serial test transmitter modules
package stt_pkg;
  // transfer sequencer states
  typedef enum logic [1:0] {
    STT_IDLE,
    STT_LOAD,
    STT_SEND
  } stt_state_e;
  // unlock sequence states
  typedef enum logic [1:0] {
    STT_LK_IDLE,
    STT_LK_ARMED,
    STT_LK_PENDING
  } stt_lock_e;
  // whole state of the top module
  typedef struct packed {
    logic [4:0]       ctrl;    // written control bits 4..0
    logic [4:0]       pend;    // control value awaiting second key
    logic [2:0][15:0] dat;     // three data registers
    logic [2:0]       dat_wr;  // data register written since last transfer
    stt_state_e       st;      // transfer sequencer
    stt_lock_e        lk;      // unlock sequence
    logic [2:0]       idx;     // next byte to queue
    logic             srst;    // soft reset pulse
    logic             waitreq; // bus waitrequest
    logic [31:0]      rdata;   // bus read data
  } stt_top_s;
endpackage

// ### rtl/stt_serializer.sv
// frames bytes onto the test output line, one bit per baud tick
`timescale 1ns/1ns
`include "stt_params.svh"
module stt_serializer (
  input  wire logic clk,
  input  wire logic clr,        // synchronous clear
  input  wire logic baud_tick,  // one pulse per bit period
  stt_stream_if.snk in_s,       // bytes to send
  output logic      line,       // output level, high when idle
  output logic      busy        // frame in progress
);
  import stt_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] sh;    // frame bits, bit now on the line in bit 0, next to send in bit 1
    logic [3:0]  left;  // bits still owed, current included
    logic        line;  // registered output level
  } stt_ser_s;
  stt_ser_s s_r, s_nxt;
  // a new frame is taken only at a bit boundary with at most the current bit owed
  assign in_s.ready = baud_tick && (s_r.left <= 4'h1);
  assign line = s_r.line;
  assign busy = (s_r.left != 4'h0);
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (baud_tick) begin
      if (s_r.left > 4'h1) begin
        s_nxt.sh   = {1'b1, s_r.sh[11:1]};
        s_nxt.line = s_r.sh[1];
        s_nxt.left = s_r.left - 4'h1;
      end else if (in_s.valid) begin
        // stop, stop, even parity, data lsb first, start
        s_nxt.sh   = {2'b11, ^in_s.data, in_s.data, 1'b0};
        s_nxt.line = 1'b0;
        s_nxt.left = `STT_FRAME_BITS; // next frame follows at once
      end else begin
        // last stop bit done, line rests high
        s_nxt.line = 1'b1;
        s_nxt.left = 4'h0;
      end
    end
  end
  // register the state
  always_ff @(posedge clk) begin
    if (clr) begin
      s_r <= '{sh: 12'hfff, left: 4'h0, line: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ### rtl/stt_stream_if.sv
// valid/ready byte stream between the transmitter's modules
`timescale 1ns/1ns
interface stt_stream_if #(parameter int W = 8);
  logic         valid; // source offers data
  logic         ready; // sink takes it this cycle
  logic [W-1:0] data;  // payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ### rtl/stt_top.sv
// serial test transmitter: keyed control, data registers, avalon slave
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`include "stt_params.svh"
module stt_top #(
  parameter int FIFO_DEPTH = `STT_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        baud_tick,
  output logic             serial_test_output
);
  import stt_pkg::*;

  // ---------------------------------------------------------------
  // state and internal wires
  // ---------------------------------------------------------------
  stt_top_s t_r;          // all registered state
  stt_top_s t_nxt;        // its next value
  logic     sub_clr;      // clear for fifo and serializer
  logic     fifo_empty;   // fifo holds nothing
  logic     ser_busy;     // frame on the line
  logic     wr_go;        // write completes this edge
  logic     rd_go;        // read answer prepared this edge
  logic [2:0]  nbytes;    // byte count code, clamped
  logic [2:0]  need;      // data registers this count needs
  logic [2:0]  dat_hit;   // data register written this edge
  logic [3:0]  state_bits;// visible progress code
  logic [15:0] ctrl_view; // control register as read
  logic [15:0] wd;        // low half of the write data

  stt_stream_if #(.W(`STT_BYTE_W)) q_in ();  // top to fifo
  stt_stream_if #(.W(`STT_BYTE_W)) q_out (); // fifo to serializer

  // soft reset clears the submodules as well as this state
  assign sub_clr = sys_rst || t_r.srst;

  // ---------------------------------------------------------------
  // byte queue and bit serializer
  // ---------------------------------------------------------------
  stt_fifo #(
    .W     (`STT_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .clr   (sub_clr),
    .in_s  (q_in),
    .out_s (q_out),
    .empty (fifo_empty)
  );

  stt_serializer u_ser (
    .clk       (clk),
    .clr       (sub_clr),
    .baud_tick (baud_tick),
    .in_s      (q_out),
    .line      (serial_test_output),
    .busy      (ser_busy)
  );

  // ---------------------------------------------------------------
  // outputs straight from flops
  // ---------------------------------------------------------------
  assign avs_readdata    = t_r.rdata;
  assign avs_waitrequest = t_r.waitreq;

  // ---------------------------------------------------------------
  // derived views
  // ---------------------------------------------------------------
  always_comb begin
    wd = avs_writedata[15:0];
    // request completes on the edge that sees waitrequest low
    wr_go = avs_write && !t_r.waitreq;
    rd_go = avs_read && t_r.waitreq;
    // which data register a completing write lands in
    dat_hit[0] = wr_go && (avs_address == `STT_ADDR_DAT0);
    dat_hit[1] = wr_go && (avs_address == `STT_ADDR_DAT1);
    dat_hit[2] = wr_go && (avs_address == `STT_ADDR_DAT2);
    // codes above six bytes are clamped, they have no meaning
    if (t_r.ctrl[`STT_CTRL_CNT_HI:`STT_CTRL_CNT_LO] > `STT_CNT_MAX) begin
      nbytes = `STT_CNT_MAX;
    end else begin
      nbytes = t_r.ctrl[`STT_CTRL_CNT_HI:`STT_CTRL_CNT_LO];
    end
    // one data register per started pair of bytes
    unique case (nbytes[2:1])
      2'b00:   need = 3'b001;
      2'b01:   need = 3'b011;
      default: need = 3'b111;
    endcase
    // progress code, zero only when fully idle
    unique case (t_r.st)
      STT_IDLE: state_bits = 4'h0;
      STT_LOAD: state_bits = `STT_STATE_LOAD;
      STT_SEND: state_bits = `STT_STATE_SEND;
    endcase
    // reserved bits read zero; written bits read back as written
    ctrl_view = {7'h00, state_bits, t_r.ctrl};
  end

  // ---------------------------------------------------------------
  // queue feed: one byte per cycle while loading
  // ---------------------------------------------------------------
  always_comb begin
    q_in.valid = (t_r.st == STT_LOAD);
    // low byte of a register goes before its high byte
    q_in.data = t_r.idx[0] ? t_r.dat[t_r.idx[2:1]][15:8]
                           : t_r.dat[t_r.idx[2:1]][7:0];
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    t_nxt = t_r;
    t_nxt.srst = 1'b0;

    // bus handshake: one wait cycle, then answer for one cycle
    if ((avs_read || avs_write) && t_r.waitreq) begin
      t_nxt.waitreq = 1'b0;
    end else begin
      t_nxt.waitreq = 1'b1;
    end

    // read decode; keys are write only, unmapped reads give zero
    if (rd_go) begin
      unique case (avs_address)
        `STT_ADDR_CTRL: t_nxt.rdata = {16'h0000, ctrl_view};
        `STT_ADDR_DAT0: t_nxt.rdata = {16'h0000, t_r.dat[0]};
        `STT_ADDR_DAT1: t_nxt.rdata = {16'h0000, t_r.dat[1]};
        `STT_ADDR_DAT2: t_nxt.rdata = {16'h0000, t_r.dat[2]};
        default:        t_nxt.rdata = 32'h00000000;
      endcase
    end

    // write decode and the unlock sequence
    if (wr_go) begin
      unique case (avs_address)
        `STT_ADDR_KEY_FIRST: begin
          // only the right first key arms the sequence
          if (wd == `STT_KEY_FIRST_VAL) begin
            t_nxt.lk = STT_LK_ARMED;
          end else begin
            t_nxt.lk = STT_LK_IDLE;
          end
        end
        `STT_ADDR_CTRL: begin
          // held back until the second key; dropped if not armed
          if (t_r.lk == STT_LK_ARMED) begin
            t_nxt.pend = wd[4:0]; // bits 15..5 not stored
            t_nxt.lk   = STT_LK_PENDING;
          end else begin
            t_nxt.lk = STT_LK_IDLE;
          end
        end
        `STT_ADDR_KEY_SECOND: begin
          t_nxt.lk = STT_LK_IDLE;
          // commit only right after a held control write
          if (t_r.lk == STT_LK_PENDING && wd == `STT_KEY_SECOND_VAL) begin
            if (t_r.pend[`STT_CTRL_SRST]) begin
              t_nxt.srst = 1'b1;
            end else begin
              t_nxt.ctrl = t_r.pend; // enable or disable
            end
          end
        end
        `STT_ADDR_DAT0, `STT_ADDR_DAT1, `STT_ADDR_DAT2: begin
          // a data register write breaks the key sequence
          t_nxt.lk = STT_LK_IDLE;
          if (avs_address == `STT_ADDR_DAT0) begin
            t_nxt.dat[0]    = wd;
            t_nxt.dat_wr[0] = 1'b1;
          end else if (avs_address == `STT_ADDR_DAT1) begin
            t_nxt.dat[1]    = wd;
            t_nxt.dat_wr[1] = 1'b1;
          end else begin
            t_nxt.dat[2]    = wd;
            t_nxt.dat_wr[2] = 1'b1;
          end
        end
        default: begin
          // unmapped writes are ignored and leave the sequence alone
        end
      endcase
    end

    // transfer sequencer
    unique case (t_r.st)
      STT_IDLE: begin
        // start once enabled and every needed register is written
        if (t_r.ctrl[`STT_CTRL_EN] && ((t_r.dat_wr & need) == need)) begin
          t_nxt.st  = STT_LOAD;
          t_nxt.idx = 3'h0;
        end
      end
      STT_LOAD: begin
        // fifo back-pressure stalls the feed
        if (q_in.ready) begin
          if (t_r.idx == nbytes) begin
            t_nxt.st = STT_SEND;
          end else begin
            t_nxt.idx = t_r.idx + 3'h1;
          end
        end
      end
      STT_SEND: begin
        // idle only after the final stop bit has left the line
        if (fifo_empty && !ser_busy) begin
          t_nxt.st = STT_IDLE;
          // data must be written afresh for the next transfer;
          // a data write on this very edge survives, set wins
          t_nxt.dat_wr = dat_hit;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register; soft reset also clears the control bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || t_r.srst) begin
      t_r.ctrl   <= `STT_CTRL_RESET;
      t_r.pend   <= `STT_CTRL_RESET;
      t_r.dat    <= {3{`STT_DAT_RESET}};
      t_r.dat_wr <= 3'b000;
      t_r.st     <= STT_IDLE;
      t_r.lk     <= STT_LK_IDLE;
      t_r.idx    <= 3'h0;
      t_r.srst   <= 1'b0;
      t_r.waitreq <= 1'b1;
      t_r.rdata  <= 32'h00000000;
    end else begin
      t_r <= t_nxt;
    end
  end

  // the pin-function selection that routes this line to the pin
  // sits outside this block; software sets it before use
endmodule

// ### testbench/stt_rx_model.sv
// passive serial receiver at the test output pin
`timescale 1ns/1ns
module stt_rx_model (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  baud_tick, // shared bit period strobe
  input  wire logic  line,      // test output level
  output logic       rx_stb,    // one cycle per byte
  output logic [7:0] rx_byte,   // received data
  output logic       rx_err     // sticky framing or parity fault
);
  logic [3:0] cnt_r; // sample index, 0 while idle
  logic [8:0] sh_r;  // data then parity, lsb first
  // ----
  // sample on each tick the bit of the past period
  // ----
  always_ff @(posedge clk) begin
    rx_stb <= 1'b0;
    if (sys_rst) begin
      cnt_r  <= 4'h0;
      rx_err <= 1'b0;
    end else if (baud_tick && cnt_r == 4'h0) begin
      if (!line) cnt_r <= 4'h1; // start bit
    end else if (baud_tick) begin
      cnt_r <= (cnt_r == 4'hb) ? 4'h0 : cnt_r + 4'h1; // back to back allowed
      if (cnt_r < 4'ha) sh_r <= {line, sh_r[8:1]}; // lsb first, then parity
      if (cnt_r > 4'h9 && !line) rx_err <= 1'b1; // two stop bits
      if (cnt_r == 4'hb) begin
        rx_stb  <= 1'b1;
        rx_byte <= sh_r[7:0];
        if (^sh_r) rx_err <= 1'b1; // even parity
      end
    end
  end
endmodule

// ### testbench/stt_top_properties.sv
// port-level checks of the serial test transmitter
`timescale 1ns/1ns
`include "stt_params.svh"
module stt_top_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        baud_tick,
  input wire logic        serial_test_output
);
  // ----
  // frame tracker
  // ----
  typedef struct packed {logic on; logic [3:0] cnt; logic par;} stt_chk_s;
  stt_chk_s chk_r;   // sample index and running parity
  stt_chk_s chk_nxt; // next tracker value
  logic     ctrl_rd; // control register read being answered
  assign ctrl_rd = avs_read && !avs_waitrequest && avs_address == `STT_ADDR_CTRL;
  // a tick samples the bit that stood during the past period
  always_comb begin
    chk_nxt = chk_r;
    if (baud_tick && !chk_r.on) begin
      chk_nxt = '{on: !serial_test_output, cnt: 4'h1, par: 1'b0};
    end else if (baud_tick) begin
      chk_nxt.cnt = chk_r.cnt + 4'h1;
      chk_nxt.par = (chk_r.cnt < 4'h9) ? chk_r.par ^ serial_test_output : chk_r.par;
      chk_nxt.on  = (chk_r.cnt != 4'hb);
    end
  end
  // cleared by reset only; a soft reset never cuts a frame in these tests
  always_ff @(posedge clk) begin
    chk_r <= sys_rst ? '0 : chk_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_idle_state: assert property ($fell(sys_rst) |-> avs_waitrequest && serial_test_output)
    else $error("bus or line busy after reset");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_request_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_answer_has_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_ctrl_upper_zero: assert property (ctrl_rd |-> avs_readdata[31:9] == 23'h0)
    else $error("control upper bits not zero");
  a_busy_state_set: assert property (ctrl_rd && chk_r.on |-> avs_readdata[8:5] != 4'h0)
    else $error("state bits zero while sending");
  a_line_on_tick: assert property (!baud_tick |=> $stable(serial_test_output))
    else $error("line moved without a tick");
  a_stop_bits_high: assert property (baud_tick && chk_r.on && chk_r.cnt > 4'h9 |-> serial_test_output)
    else $error("stop bit low");
  a_parity_even: assert property (baud_tick && chk_r.on && chk_r.cnt == 4'h9 |-> serial_test_output == chk_r.par)
    else $error("parity bit wrong");
endmodule
bind stt_top stt_top_properties i_props (
  .clk(clk),
  .sys_rst(sys_rst),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .baud_tick(baud_tick),
  .serial_test_output(serial_test_output)
);

// ### testbench/stt_top_tb.sv
// self-checking bench of the serial test transmitter
`timescale 1ns/1ns
`include "stt_params.svh"
module stt_top_tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        baud_tick = 1'b0;
  logic        serial_test_output;
  logic        rx_stb;
  logic [7:0]  rx_byte;
  logic        rx_err;
  int          num_errors = 0;
  int          tests_run = 0;
  int          div = 0;          // baud divider, one tick per 4 clocks
  int          ticks = 0;        // ticks since start
  logic [31:0] seed = 32'd99145; // random source state
  logic [7:0]  rx_q[$];          // received bytes
  int          rx_t[$];          // tick count of each byte
  // ----
  // clock, baud ticks, receiver log
  // ----
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    div <= (div + 1) % 4;
    baud_tick <= (div == 3);
    if (baud_tick) ticks <= ticks + 1;
    if (rx_stb) begin
      rx_q.push_back(rx_byte);
      rx_t.push_back(ticks);
    end
  end
  // small fifo so six bytes fill it and the serializer stalls it
  stt_top #(.FIFO_DEPTH(2)) i_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .baud_tick(baud_tick),
    .serial_test_output(serial_test_output)
  );
  // receiver listens at the output as if the pin function routes it out
  stt_rx_model i_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .baud_tick(baud_tick),
    .line(serial_test_output),
    .rx_stb(rx_stb),
    .rx_byte(rx_byte),
    .rx_err(rx_err)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // one avalon cycle; waitrequest is sampled at the rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    // hold the request until the edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 100) num_errors++;
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 16'h0, v);
    chk(what, exp, v);
  endtask
  task automatic ctrl_wr(input logic [15:0] k1, input logic [15:0] v, input logic [15:0] k2);
    wr(`STT_ADDR_KEY_FIRST, k1);
    wr(`STT_ADDR_CTRL, v);
    wr(`STT_ADDR_KEY_SECOND, k2);
  endtask
  // one keyed transfer of code+1 random bytes, at most six, polled to completion
  task automatic send(input logic [2:0] code);
    logic [15:0] d[3];
    logic [31:0] v;
    logic [15:0] cv;
    int n, nreg, busy, k;
    // codes above six bytes send six bytes
    n = ((code > `STT_CNT_MAX) ? `STT_CNT_MAX : code) + 1;
    nreg = (n + 1) / 2;
    cv = {11'h0, code, 2'b01}; // unused bits written as zero
    busy = 0;
    k = 0;
    rx_q.delete();
    rx_t.delete();
    ctrl_wr(`STT_KEY_FIRST_VAL, cv, `STT_KEY_SECOND_VAL);
    for (int i = 0; i < nreg; i++) begin
      seed = lfsr(seed);
      d[i] = seed[15:0];
      if (i == nreg - 1) rd_chk("idle until data", `STT_ADDR_CTRL, cv);
      wr(`STT_ADDR_DAT0 + 4 * i, d[i]);
    end
    do begin
      bus(1'b0, `STT_ADDR_CTRL, 16'h0, v);
      if (v[4:0] === cv[4:0] && v[8:5] !== 4'h0) busy++;
      k++;
    end while (v !== {16'h0, cv} && k < 2000);
    repeat (2) @(posedge clk);
    chk("busy readback", 1, busy > 0);
    chk("final ctrl", cv, v);
    chk("byte count", n, rx_q.size());
    for (int i = 0; i < n; i++) chk("byte", (d[i / 2] >> (8 * (i % 2))) & 16'hff, rx_q[i]);
    chk("back to back", 12 * (n - 1), rx_t[n - 1] - rx_t[0]);
  endtask
  task automatic close_out();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("ctrl reset", `STT_ADDR_CTRL, 32'h0);
    rd_chk("data reset", `STT_ADDR_DAT2, 32'h0);
    rd_chk("unmapped", 32'hffff0898, 32'h0);
    ctrl_wr(16'h0006, 16'h0001, `STT_KEY_SECOND_VAL);
    rd_chk("wrong first key", `STT_ADDR_CTRL, 32'h0);
    ctrl_wr(`STT_KEY_FIRST_VAL, 16'h0001, 16'h00b8);
    rd_chk("wrong second key", `STT_ADDR_CTRL, 32'h0);
    wr(`STT_ADDR_CTRL, 16'h0001);
    wr(`STT_ADDR_KEY_SECOND, `STT_KEY_SECOND_VAL);
    rd_chk("no first key", `STT_ADDR_CTRL, 32'h0);
    wr(`STT_ADDR_KEY_FIRST, `STT_KEY_FIRST_VAL);
    wr(`STT_ADDR_CTRL, 16'h0001);
    wr(`STT_ADDR_DAT0, 16'h1234);
    wr(`STT_ADDR_KEY_SECOND, `STT_KEY_SECOND_VAL);
    rd_chk("write between keys", `STT_ADDR_CTRL, 32'h0);
    ctrl_wr(`STT_KEY_FIRST_VAL, 16'h0017, `STT_KEY_SECOND_VAL);
    rd_chk("ctrl after soft reset", `STT_ADDR_CTRL, 32'h0);
    rd_chk("data after soft reset", `STT_ADDR_DAT0, 32'h0);
    for (int c = 0; c < 7; c++) send(c[2:0]);
    ctrl_wr(`STT_KEY_FIRST_VAL, 16'h0000, `STT_KEY_SECOND_VAL);
    wr(`STT_ADDR_DAT0, 16'h00a5);
    rd_chk("disabled stays idle", `STT_ADDR_CTRL, 32'h0);
    chk("frame fault", 0, rx_err);
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule
